// *** rtdst_core.sv ***
// Radio time decoder with zone offset and daylight saving correction
`timescale 1ns/10ps
`default_nettype none

// Function
// - Daylight flag is read from bit 57 of every received minute.
// - Flag zero means standard time, one means daylight time.
// - Zone switch at zero ignores the flag; output stays universal time.
// - Nonzero zone adds the daylight hour to display and captured time.
// - A flag change takes effect at 2:00AM local, not when received.
// - First flag after start is applied at once, even before 2:00AM.
// - Capture command latches local time in any cycle cap_req is high; cap_ack clears cap_valid only in a cycle where cap_req is low.
module rtdst_core (
  input wire logic clk_sys,
  input wire logic srst,
  input wire rtdst_pkg::rtdst_rx_type rx_pin,
  input wire logic [4:0] zone_pin,
  input wire logic cap_req,
  input wire logic cap_ack,
  output rtdst_pkg::rtdst_time_type disp_time,
  output logic dst_in_force,
  output logic time_locked,
  output rtdst_pkg::rtdst_time_type cap_time,
  output logic cap_valid
);
  import rtdst_pkg::*;

  typedef enum logic {ST_HUNT, ST_FRAME} rtdst_state_type;

  typedef struct packed {
    rtdst_rx_type rx_s1;
    rtdst_rx_type rx_s2;
    logic sync_s3;
    logic [4:0] zone_s1;
    logic [4:0] zone_s2;
    rtdst_state_type state;
    logic [5:0] pos;
    logic prev_mark;
    logic frame_ok;
    logic [5:0] acc_min;
    logic [4:0] acc_hour;
    logic [8:0] acc_day;
    logic dst_rx;
    logic dst_app;
    logic have_dst;
    logic locked;
    rtdst_time_type ut;
    rtdst_time_type disp;
    logic dst_out;
    rtdst_time_type cap;
    logic cap_valid;
  } rtdst_regs_type;

  rtdst_regs_type st_ff;
  rtdst_regs_type nxt_st;
  rtdst_time_type loc;
  rtdst_time_type dec_time;
  logic tick;
  logic is_mark;
  logic is_one;
  logic dst_eff;
  logic [5:0] pos_new;
  logic [10:0] wt;

  // ----------------------------------------------------------------
  // Local time from the running universal time
  // ----------------------------------------------------------------
  // Zero zone forces the daylight hour out so output stays universal
  assign dst_eff = (st_ff.zone_s2 != 5'h00) && st_ff.dst_app;

  rtdst_local u_local (
    .ut(st_ff.ut),
    .zone($signed(st_ff.zone_s2)),
    .dst_eff(dst_eff),
    .loc(loc)
  );

  // Symbol classification is taken on the synchronised sync edge
  assign tick = st_ff.rx_s2.sync && !st_ff.sync_s3;
  assign is_mark = st_ff.rx_s2.sym == SYM_MARK;
  assign is_one = st_ff.rx_s2.sym == SYM_ONE;
  assign pos_new = st_ff.pos + 6'h01;
  assign wt = code_weight(pos_new);

  // Decoded frame, set to its last second so one tick lands on :00
  always_comb begin
    dec_time.doy = st_ff.acc_day;
    dec_time.hour = st_ff.acc_hour;
    dec_time.min = st_ff.acc_min;
    dec_time.sec = SEC_MAX;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Pins cross into the clock domain through two stages
    nxt_st.rx_s1 = rx_pin;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.sync_s3 = st_ff.rx_s2.sync;
    nxt_st.zone_s1 = zone_pin;
    nxt_st.zone_s2 = st_ff.zone_s1;

    if (st_ff.locked && tick) begin
      nxt_st.ut = time_tick(st_ff.ut);
    end

    if (tick) begin
      nxt_st.prev_mark = is_mark;
      if (is_mark && st_ff.prev_mark) begin
        // Double marker opens a new minute; load only a complete frame
        if (st_ff.state == ST_FRAME && st_ff.frame_ok) begin
          nxt_st.ut = time_tick(dec_time);
          nxt_st.locked = 1'b1;
        end
        nxt_st.state = ST_FRAME;
        nxt_st.pos = POS_FIRST;
        nxt_st.frame_ok = 1'b0;
        nxt_st.acc_min = '0;
        nxt_st.acc_hour = '0;
        nxt_st.acc_day = '0;
      end else if (st_ff.state == ST_FRAME) begin
        nxt_st.pos = pos_new;
        if (pos_new > POS_LAST) begin
          nxt_st.state = ST_HUNT; // Lost framing, wait for double marker
        end
        if (is_one) begin
          unique case (wt[10:9])
            FLD_MIN: nxt_st.acc_min = st_ff.acc_min + wt[5:0];
            FLD_HOUR: nxt_st.acc_hour = st_ff.acc_hour + wt[4:0];
            FLD_DAY: nxt_st.acc_day = st_ff.acc_day + wt[8:0];
            FLD_NONE: nxt_st.acc_min = st_ff.acc_min;
          endcase
        end
        if (pos_new == POS_DST) begin
          nxt_st.dst_rx = is_one;
          if (!st_ff.have_dst) begin
            nxt_st.dst_app = is_one;
            nxt_st.have_dst = 1'b1;
          end
        end
        if (pos_new == POS_LAST && is_mark) begin
          nxt_st.frame_ok = 1'b1;
        end
      end
    end

    // Held flag only swaps in at 2:00:00 local of the configured zone
    if (st_ff.have_dst && loc.hour == DST_HOUR && loc.min == DST_MIN &&
        loc.sec == DST_SEC) begin
      nxt_st.dst_app = st_ff.dst_rx;
    end

    nxt_st.disp = loc;
    nxt_st.dst_out = dst_eff;

    // A new capture wins over the read-done clear in the same cycle
    if (cap_req) begin
      nxt_st.cap = loc;
      nxt_st.cap_valid = 1'b1;
    end else if (cap_ack) begin
      nxt_st.cap_valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.ut.doy <= DAY_FIRST;
      st_ff.disp.doy <= DAY_FIRST;
      st_ff.cap.doy <= DAY_FIRST;
      st_ff.state <= ST_HUNT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign disp_time = st_ff.disp;
  assign dst_in_force = st_ff.dst_out;
  assign time_locked = st_ff.locked;
  assign cap_time = st_ff.cap;
  assign cap_valid = st_ff.cap_valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_dst_bit_one: assert property (@(posedge clk_sys) disable iff (srst)
    tick && st_ff.state == ST_FRAME && pos_new == POS_DST && is_one &&
    !(is_mark && st_ff.prev_mark) |=> st_ff.dst_rx)
    else $error("flag one at bit 57 not taken");

  a_dst_bit_zero: assert property (@(posedge clk_sys) disable iff (srst)
    tick && st_ff.state == ST_FRAME && pos_new == POS_DST &&
    st_ff.rx_s2.sym == SYM_ZERO |=> !st_ff.dst_rx ##1
    (!dst_in_force || $past(st_ff.dst_app)))
    else $error("flag zero at bit 57 not taken");

  a_utc_pass: assert property (@(posedge clk_sys) disable iff (srst)
    st_ff.zone_s2 == 5'h00 |=> disp_time == $past(st_ff.ut))
    else $error("zero zone does not show universal time");

  a_dst_adds: assert property (@(posedge clk_sys) disable iff (srst)
    st_ff.zone_s2 != 5'h00 && $stable(st_ff.zone_s2) &&
    $stable(st_ff.ut) && $rose(st_ff.dst_app)
    |=> disp_time != $past(disp_time) && dst_in_force)
    else $error("daylight hour not applied");

  a_dst_at_two: assert property (@(posedge clk_sys) disable iff (srst)
    $past(st_ff.have_dst) && $changed(st_ff.dst_app) |->
    $past(loc.hour) == DST_HOUR && $past(loc.min) == DST_MIN)
    else $error("daylight change outside 2:00 local");

  a_dst_first: assert property (@(posedge clk_sys) disable iff (srst)
    !st_ff.have_dst && tick && st_ff.state == ST_FRAME &&
    pos_new == POS_DST && !(is_mark && st_ff.prev_mark)
    |=> st_ff.have_dst && st_ff.dst_app == st_ff.dst_rx)
    else $error("first flag not applied at once");

  a_cap_latch: assert property (@(posedge clk_sys) disable iff (srst)
    cap_req |=> cap_valid && cap_time == $past(loc))
    else $error("capture did not latch local time");

  a_hour_range: assert property (@(posedge clk_sys) disable iff (srst)
    disp_time.hour <= HOUR_MAX && disp_time.doy >= DAY_FIRST &&
    disp_time.doy <= DAYS_YEAR)
    else $error("local hour or day out of range");

  c_frame_load: cover property (@(posedge clk_sys) disable iff (srst)
    $rose(st_ff.locked));
  c_dst_switch: cover property (@(posedge clk_sys) disable iff (srst)
    st_ff.have_dst && $changed(st_ff.dst_app));
  c_capture: cover property (@(posedge clk_sys) disable iff (srst)
    cap_valid && cap_ack && !cap_req ##1 !cap_valid);

endmodule // rtdst_core

`default_nettype wire

// *** rtdst_core_tb_top.sv ***
// Self-checking testbench for the local-time and daylight block
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Testbench top
// ----------------------------------------------------------------
module rtdst_core_tb_top;
  import rtdst_pkg::*;

  logic clk_sys, srst, en, f_dst, cap_req, cap_ack;
  logic [4:0] zone_pin;
  rtdst_time_type f_time, disp_time, cap_time;
  rtdst_rx_type rx_pin;
  logic dst_in_force, time_locked, cap_valid;
  logic [5:0] pos_o;
  int err_count, checks_done, cyc;

  rtdst_core u_dut (.clk_sys(clk_sys), .srst(srst), .rx_pin(rx_pin),
    .zone_pin(zone_pin), .cap_req(cap_req), .cap_ack(cap_ack),
    .disp_time(disp_time), .dst_in_force(dst_in_force),
    .time_locked(time_locked), .cap_time(cap_time), .cap_valid(cap_valid));

  rtdst_fe_model #(.SEC_CLKS(16)) u_fe (.clk_sys(clk_sys), .en(en),
    .f_time(f_time), .f_dst(f_dst), .rx_pin(rx_pin), .pos_o(pos_o));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Waits for the model to enter second p; sampled before its update
  task automatic wait_pos(input logic [5:0] p);
    int n;
    n = 0;
    while (pos_o == p && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    while (pos_o != p && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
  endtask

  // Frame t is sent whole, loaded at the next double marker, checked s on
  task automatic run_minute(input rtdst_time_type t, input logic d,
    input logic [5:0] s, input rtdst_time_type et, input logic ed);
    f_time = t;
    f_dst = d;
    wait_pos(6'h3a);
    wait_pos(6'h00);
    wait_pos(6'h00);
    if (s != 6'h00) wait_pos(s);
    step(10);
    chk("disp_time", 32'(disp_time), 32'(et));
    chk("dst_in_force", 32'(dst_in_force), 32'(ed));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset();
    chk("disp_time", 32'(disp_time), 32'({9'h001, 17'h0}));
    chk("time_locked", 32'(time_locked), 32'h0);
    chk("cap_valid", 32'(cap_valid), 32'h0);
  endtask

  // Zone -5, flag set at first lock: applied at once, borrow a day
  task automatic sc_first_flag();
    run_minute({9'h064, 5'h01, 6'h1e, 6'h00}, 1'b1, 6'h00,
      {9'h063, 5'h15, 6'h1f, 6'h00}, 1'b1);
    chk("time_locked", 32'(time_locked), 32'h1);
  endtask

  // Flag clears, but local 01:59 keeps the daylight hour
  task automatic sc_hold_change();
    zone_pin = 5'h1b;
    run_minute({9'h064, 5'h05, 6'h3a, 6'h00}, 1'b0, 6'h00,
      {9'h064, 5'h01, 6'h3b, 6'h00}, 1'b1);
  endtask

  // Local 2:00 reached: daylight hour removed, shows 01:00:02
  task automatic sc_fall_back();
    run_minute({9'h064, 5'h05, 6'h3b, 6'h00}, 1'b0, 6'h02,
      {9'h064, 5'h01, 6'h00, 6'h02}, 1'b0);
  endtask

  // Zone zero shows universal time and dst_in_force low while the flag is set
  task automatic sc_zone_zero();
    zone_pin = 5'h00;
    run_minute({9'h064, 5'h0c, 6'h00, 6'h00}, 1'b1, 6'h00,
      {9'h064, 5'h0c, 6'h01, 6'h00}, 1'b0);
  endtask

  // Zone +12 carries past day 365 into day 1, then capture
  task automatic sc_carry_capture();
    rtdst_time_type et;
    et = {9'h001, 5'h0b, 6'h00, 6'h00};
    zone_pin = 5'h0c;
    run_minute({9'h16d, 5'h16, 6'h3b, 6'h00}, 1'b1, 6'h00, et,
      1'b0);
    cap_req = 1'b1;
    step(1);
    cap_req = 1'b0;
    step(1);
    chk("cap_valid", 32'(cap_valid), 32'h1);
    chk("cap_time", 32'(cap_time), 32'(et));
    cap_req = 1'b1;
    cap_ack = 1'b1;
    step(1);
    cap_req = 1'b0;
    cap_ack = 1'b0;
    step(1);
    chk("cap_valid", 32'(cap_valid), 32'h1);
    cap_ack = 1'b1;
    step(1);
    cap_ack = 1'b0;
    step(1);
    chk("cap_valid", 32'(cap_valid), 32'h0);
  endtask

  // Hang guard: the run needs well under half this many cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    en = 1'b0;
    zone_pin = 5'h1b;
    f_time = '0;
    f_dst = 1'b0;
    cap_req = 1'b0;
    cap_ack = 1'b0;
    step(4);
    srst = 1'b0;
    step(1);
    sc_reset();
    en = 1'b1;
    sc_first_flag();
    sc_zone_zero();
    sc_hold_change();
    sc_fall_back();
    sc_carry_capture();
    report_and_stop();
  end
endmodule // rtdst_core_tb_top

`default_nettype wire

// *** rtdst_fe_model.sv ***
// Behavioural radio front end: one time-code frame per minute
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Front-end model
// ----------------------------------------------------------------
module rtdst_fe_model #(
  parameter int SEC_CLKS = 16
) (
  input wire logic clk_sys,
  input wire logic en,
  input wire rtdst_pkg::rtdst_time_type f_time,
  input wire logic f_dst,
  output rtdst_pkg::rtdst_rx_type rx_pin,
  output logic [5:0] pos_o
);
  import rtdst_pkg::*;

  rtdst_time_type lt;
  logic ld;

  // Frame bit at position p, built from plain decimal digits
  function automatic logic bitv(input int p);
    int m;
    int h;
    int d;
    m = lt.min;
    h = lt.hour;
    d = lt.doy;
    case (p)
      1, 2, 3: return ((m / 10) >> (3 - p)) % 2 == 1;
      5, 6, 7, 8: return ((m % 10) >> (8 - p)) % 2 == 1;
      12, 13: return ((h / 10) >> (13 - p)) % 2 == 1;
      15, 16, 17, 18: return ((h % 10) >> (18 - p)) % 2 == 1;
      22, 23: return ((d / 100) >> (23 - p)) % 2 == 1;
      25, 26, 27, 28: return ((d / 10 % 10) >> (28 - p)) % 2 == 1;
      30, 31, 32, 33: return ((d % 10) >> (33 - p)) % 2 == 1;
      57: return ld;
      default: return 1'b0;
    endcase
  endfunction

  // One symbol per second: marker, one or zero
  function automatic logic [1:0] sym_of(input int p);
    if (p == 0 || p % 10 == 9) return SYM_MARK;
    return bitv(p) ? SYM_ONE : SYM_ZERO;
  endfunction

  // One second: symbol first, then the boundary pulse
  task automatic one_second();
    #1;
    pos_o = (pos_o == 6'h3b) ? 6'h00 : pos_o + 6'h01;
    if (pos_o == 6'h00) begin
      lt = f_time;
      ld = f_dst;
    end
    rx_pin.sym = sym_of(int'(pos_o));
    @(posedge clk_sys);
    #1 rx_pin.sync = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 rx_pin.sync = 1'b0;
    repeat (2) @(posedge clk_sys);
    // Hold time over, so the line stops showing the symbol
    #1 rx_pin.sym = ~rx_pin.sym;
    repeat (SEC_CLKS - 7) @(posedge clk_sys);
  endtask

  // Sync stands still while disabled, as before lock
  initial begin
    rx_pin = '0;
    pos_o = 6'h3a;
    lt = '0;
    ld = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (en) one_second();
    end
  end
endmodule // rtdst_fe_model

`default_nettype wire

// *** rtdst_pkg.sv ***
// Shared types and constants, plus the local-hour adjuster leaf module
package rtdst_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] doy;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtdst_time_type;

  typedef struct packed {
    logic sync;
    logic [1:0] sym;
  } rtdst_rx_type;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_ONE = 2'h1;
  localparam logic [1:0] SYM_MARK = 2'h2;
  localparam logic [5:0] POS_FIRST = 6'h00;
  localparam logic [5:0] POS_DST = 6'h39;
  localparam logic [5:0] POS_LAST = 6'h3b;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic signed [7:0] HOURS_DAY = 8'sh18;
  localparam logic [8:0] DAY_FIRST = 9'h001;
  localparam logic [8:0] DAYS_YEAR = 9'h16d;
  localparam logic [4:0] DST_HOUR = 5'h02;
  localparam logic [5:0] DST_MIN = 6'h00;
  localparam logic [5:0] DST_SEC = 6'h00;

  // Field selector returned by the code weight table
  localparam logic [1:0] FLD_NONE = 2'h0;
  localparam logic [1:0] FLD_MIN = 2'h1;
  localparam logic [1:0] FLD_HOUR = 2'h2;
  localparam logic [1:0] FLD_DAY = 2'h3;

  // Weight of a one bit at each frame position: {field, weight}
  function automatic logic [10:0] code_weight(input logic [5:0] pos);
    unique case (pos)
      6'h01: code_weight = {FLD_MIN, 9'h028};
      6'h02: code_weight = {FLD_MIN, 9'h014};
      6'h03: code_weight = {FLD_MIN, 9'h00a};
      6'h05: code_weight = {FLD_MIN, 9'h008};
      6'h06: code_weight = {FLD_MIN, 9'h004};
      6'h07: code_weight = {FLD_MIN, 9'h002};
      6'h08: code_weight = {FLD_MIN, 9'h001};
      6'h0c: code_weight = {FLD_HOUR, 9'h014};
      6'h0d: code_weight = {FLD_HOUR, 9'h00a};
      6'h0f: code_weight = {FLD_HOUR, 9'h008};
      6'h10: code_weight = {FLD_HOUR, 9'h004};
      6'h11: code_weight = {FLD_HOUR, 9'h002};
      6'h12: code_weight = {FLD_HOUR, 9'h001};
      6'h16: code_weight = {FLD_DAY, 9'h0c8};
      6'h17: code_weight = {FLD_DAY, 9'h064};
      6'h19: code_weight = {FLD_DAY, 9'h050};
      6'h1a: code_weight = {FLD_DAY, 9'h028};
      6'h1b: code_weight = {FLD_DAY, 9'h014};
      6'h1c: code_weight = {FLD_DAY, 9'h00a};
      6'h1e: code_weight = {FLD_DAY, 9'h008};
      6'h1f: code_weight = {FLD_DAY, 9'h004};
      6'h20: code_weight = {FLD_DAY, 9'h002};
      6'h21: code_weight = {FLD_DAY, 9'h001};
      default: code_weight = {FLD_NONE, 9'h000};
    endcase
  endfunction

  // One second forward, rolling into minutes, hours and day of year
  function automatic rtdst_time_type time_tick(input rtdst_time_type t);
    rtdst_time_type r;
    r = t;
    if (t.sec < SEC_MAX) begin
      r.sec = t.sec + 6'h01;
    end else begin
      r.sec = '0;
      if (t.min < MIN_MAX) begin
        r.min = t.min + 6'h01;
      end else begin
        r.min = '0;
        if (t.hour < HOUR_MAX) begin
          r.hour = t.hour + 5'h01;
        end else begin
          r.hour = '0;
          r.doy = (t.doy >= DAYS_YEAR) ? DAY_FIRST : t.doy + 9'h001;
        end
      end
    end
    return r;
  endfunction

endpackage

`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Local hour adjuster: universal hours plus zone plus daylight hour
// ------------------------------------------------------------------
module rtdst_local (
  input wire rtdst_pkg::rtdst_time_type ut,
  input wire logic signed [4:0] zone,
  input wire logic dst_eff,
  output rtdst_pkg::rtdst_time_type loc
);
  import rtdst_pkg::*;

  logic signed [7:0] hsum;

  // Day of year follows the hour carry or borrow; leap years not known
  always_comb begin
    hsum = $signed({3'h0, ut.hour}) + 8'(zone) + $signed({7'h00, dst_eff});
    loc = ut;
    if (hsum >= HOURS_DAY) begin
      loc.hour = 5'(hsum - HOURS_DAY);
      loc.doy = (ut.doy >= DAYS_YEAR) ? DAY_FIRST : ut.doy + 9'h001;
    end else if (hsum < 8'sh00) begin
      loc.hour = 5'(hsum + HOURS_DAY);
      loc.doy = (ut.doy <= DAY_FIRST) ? DAYS_YEAR : ut.doy - 9'h001;
    end else begin
      loc.hour = 5'(hsum);
    end
  end

endmodule // rtdst_local

`default_nettype wire
